// ### rtl/jbst_pkg.sv
/*
  Constants, state codes and carrier types for the boundary-scan test port.
  Assumes a single 100 MHz bus clock; the test clock arrives as a plain pin.
*/
package jbst_pkg;
  // Clock period of pclk in ns
  localparam int          CLK_PERIOD_NS   = 10;
  // Instruction register
  localparam int          IR_W            = 4;
  localparam logic [3:0]  OP_EXTEST       = 4'h0;
  localparam logic [3:0]  OP_IDCODE       = 4'h1;
  localparam logic [3:0]  OP_SAMPLE       = 4'h2;
  localparam logic [3:0]  OP_CHIP_RESET   = 4'hc;  // chip_reset_instruction
  localparam logic [3:0]  OP_BYPASS       = 4'hf;
  localparam logic [3:0]  IR_CAPTURE_VAL  = 4'h1;
  // Identification word layout
  localparam int          ID_W            = 32;
  localparam int          ID_MFR_LSB      = 1;
  localparam int          ID_PART_LSB     = 12;
  localparam int          ID_VER_LSB      = 28;
  // Boundary chain: three cells per pin, then analog interface cells
  localparam int          NUM_PINS        = 8;
  localparam int          NUM_ANALOG      = 2;
  localparam int          CELLS_PER_PIN   = 3;
  localparam int          CELL_DATA       = 0;
  localparam int          CELL_CTRL       = 1;
  localparam int          CELL_PUD        = 2;
  localparam int          BSC_W           = NUM_PINS * CELLS_PER_PIN + NUM_ANALOG;
  // APB map
  localparam logic [11:0] ADDR_CTRL       = 12'h000;
  localparam logic [11:0] ADDR_STATUS     = 12'h004;
  localparam logic [11:0] ADDR_IDCODE     = 12'h008;
  localparam int          CTRL_DIS_BIT    = 0;
  localparam logic        CTRL_DIS_RST    = 1'b0;
  localparam int          ST_IR_LSB       = 0;
  localparam int          ST_ENABLED_BIT  = 4;
  localparam int          ST_RESET_BIT    = 5;
  localparam int          ST_TAPRST_BIT   = 6;
  localparam int          ST_STATE_LSB    = 16;
  // Reset time-out options, times in microseconds
  localparam int          TO_SHORT_US     = 4;
  localparam int          TO_SHORT_CYC    = TO_SHORT_US * 1000 / CLK_PERIOD_NS;
  localparam int          TO_MID_US       = 4100;
  localparam int          TO_LONG_US      = 65000;

  // One-hot test controller states
  typedef enum logic [15:0] {
    TAP_RESET   = 16'h0001,
    TAP_IDLE    = 16'h0002,
    TAP_SEL_DR  = 16'h0004,
    TAP_CAP_DR  = 16'h0008,
    TAP_SH_DR   = 16'h0010,
    TAP_EX1_DR  = 16'h0020,
    TAP_PA_DR   = 16'h0040,
    TAP_EX2_DR  = 16'h0080,
    TAP_UPD_DR  = 16'h0100,
    TAP_SEL_IR  = 16'h0200,
    TAP_CAP_IR  = 16'h0400,
    TAP_SH_IR   = 16'h0800,
    TAP_EX1_IR  = 16'h1000,
    TAP_PA_IR   = 16'h2000,
    TAP_EX2_IR  = 16'h4000,
    TAP_UPD_IR  = 16'h8000
  } jbst_tap_state_t;

  // Data path selected by the instruction
  typedef enum logic [1:0] {
    SEL_BSC    = 2'h0,
    SEL_ID     = 2'h1,
    SEL_RST    = 2'h2,
    SEL_BYPASS = 2'h3
  } jbst_sel_t;

  // Test port input pins
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } jbst_jtag_in_t;

  // Port pin group, one bit per pin
  typedef struct packed {
    logic [NUM_PINS-1:0] data;
    logic [NUM_PINS-1:0] oe;
    logic [NUM_PINS-1:0] pud;
  } jbst_pins_t;
endpackage

// ### rtl/jbst_tap.sv
/*
  Boundary-scan test access port with instruction register, bypass,
  identification, chip reset and boundary chain data registers, plus an
  APB slave for the disable bit and status.
  Assumes TCK, TMS, TDI and the pad inputs are asynchronous to pclk and
  TCK is well below pclk/4; the fuse inputs are static levels.
*/
`timescale 1ns/1ps
module jbst_tap
  import jbst_pkg::*;
#(
  parameter logic [3:0]  ID_VERSION = 4'h0,      // silicon revision, 0 = first
  parameter logic [15:0] ID_PART    = 16'h5a5a,  // arbitrary value
  parameter logic [10:0] ID_MFR     = 11'h155,   // arbitrary value
  parameter int          TO_MID_CYC  = TO_MID_US * (1000 / CLK_PERIOD_NS),
  parameter int          TO_LONG_CYC = TO_LONG_US * (1000 / CLK_PERIOD_NS)
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire jbst_jtag_in_t       jtag_in,
  output logic                     tdo,
  output logic                     tdo_oe,
  input  wire logic                tap_enable_fuse,
  input  wire logic [1:0]          clock_option_fuse,
  input  wire jbst_pins_t          core_pins,
  input  wire logic [NUM_PINS-1:0] pin_in,
  input  wire logic [NUM_ANALOG-1:0] analog_if,
  output jbst_pins_t               pad_pins,
  output logic                     core_reset
);

  localparam logic [ID_W-1:0] ID_VALUE = {ID_VERSION, ID_PART, ID_MFR, 1'b1};

  // Instruction to data path decode
  function automatic jbst_sel_t dr_sel(input logic [IR_W-1:0] op);
    case (op)
      OP_EXTEST, OP_SAMPLE: dr_sel = SEL_BSC;
      OP_IDCODE:            dr_sel = SEL_ID;
      OP_CHIP_RESET:        dr_sel = SEL_RST;
      default:              dr_sel = SEL_BYPASS;
    endcase
  endfunction

  // Controller next state for one TCK rising edge
  function automatic jbst_tap_state_t tap_next(input jbst_tap_state_t s, input logic tms);
    case (s)
      TAP_RESET:  tap_next = tms ? TAP_RESET  : TAP_IDLE;
      TAP_IDLE:   tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: tap_next = tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: tap_next = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR:  tap_next = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: tap_next = tms ? TAP_UPD_DR : TAP_PA_DR;
      TAP_PA_DR:  tap_next = tms ? TAP_EX2_DR : TAP_PA_DR;
      TAP_EX2_DR: tap_next = tms ? TAP_UPD_DR : TAP_SH_DR;
      TAP_UPD_DR: tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: tap_next = tms ? TAP_RESET  : TAP_CAP_IR;
      TAP_CAP_IR: tap_next = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR:  tap_next = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: tap_next = tms ? TAP_UPD_IR : TAP_PA_IR;
      TAP_PA_IR:  tap_next = tms ? TAP_EX2_IR : TAP_PA_IR;
      TAP_EX2_IR: tap_next = tms ? TAP_UPD_IR : TAP_SH_IR;
      TAP_UPD_IR: tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
      default:    tap_next = TAP_RESET;
    endcase
  endfunction

  // Synchronisers for test pins and pads
  jbst_jtag_in_t       jtag_s1;
  jbst_jtag_in_t       jtag_s2;
  logic                tck_prev;
  logic [NUM_PINS-1:0] pin_s1;
  logic [NUM_PINS-1:0] pin_s2;
  logic [NUM_ANALOG-1:0] ana_s1;
  logic [NUM_ANALOG-1:0] ana_s2;
  logic                tck_rise;
  logic                tck_fall;

  // Test controller group
  jbst_tap_state_t     state;
  jbst_tap_state_t     next_state;
  logic [IR_W-1:0]     ir;
  logic [IR_W-1:0]     next_ir;
  logic [IR_W-1:0]     ir_shift;
  logic [IR_W-1:0]     next_ir_shift;
  logic [ID_W-1:0]     id_shift;
  logic [ID_W-1:0]     next_id_shift;
  logic                bypass;
  logic                next_bypass;
  logic                reset_dr;
  logic                next_reset_dr;
  logic [BSC_W-1:0]    bsc_shift;
  logic [BSC_W-1:0]    next_bsc_shift;
  logic [BSC_W-1:0]    bsc_upd;
  logic [BSC_W-1:0]    next_bsc_upd;
  logic                next_tdo;
  logic                next_tdo_oe;
  logic [BSC_W-1:0]    bsc_capture;
  jbst_sel_t           sel;
  logic                tap_en;
  logic                scan_mode;
  logic                extest_on;

  // Reset time-out group
  logic [31:0]         rst_cnt;
  logic [31:0]         next_rst_cnt;
  logic [31:0]         rst_load;

  // APB register group
  logic                tap_disable_bit;
  logic                next_tap_disable_bit;
  logic                tap_reset_flag;
  logic                next_tap_reset_flag;
  logic [31:0]         next_prdata;
  logic                addr_hit;
  logic                wr_en;

  // Pad drive group
  jbst_pins_t          pad_q;
  jbst_pins_t          next_pad;

  // Two-stage synchronisers; the first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      jtag_s1  <= '0;
      jtag_s2  <= '0;
      tck_prev <= 1'b0;
      pin_s1   <= '0;
      pin_s2   <= '0;
      ana_s1   <= '0;
      ana_s2   <= '0;
    end else begin
      jtag_s1  <= jtag_in;
      jtag_s2  <= jtag_s1;
      tck_prev <= jtag_s2.tck;
      pin_s1   <= pin_in;
      pin_s2   <= pin_s1;
      ana_s1   <= analog_if;
      ana_s2   <= ana_s1;
    end
  end

  // TCK edges found on the bus clock; core clock never involved
  assign tck_rise  = jtag_s2.tck & ~tck_prev;
  assign tck_fall  = ~jtag_s2.tck & tck_prev;
  assign tap_en    = tap_enable_fuse & ~tap_disable_bit;
  assign sel       = dr_sel(ir);
  assign extest_on = tap_en & (ir == OP_EXTEST);
  assign scan_mode = tap_en & ((ir == OP_EXTEST) | (ir == OP_SAMPLE));

  // Capture vector: pin input, core control, core pull-up, then analog
  generate
    for (genvar i = 0; i < NUM_PINS; i++) begin : g_cap
      assign bsc_capture[i*CELLS_PER_PIN + CELL_DATA] = pin_s2[i];
      assign bsc_capture[i*CELLS_PER_PIN + CELL_CTRL] = core_pins.oe[i];
      assign bsc_capture[i*CELLS_PER_PIN + CELL_PUD]  = core_pins.pud[i];
    end
  endgenerate
  assign bsc_capture[BSC_W-1 -: NUM_ANALOG] = ana_s2;

  // Test controller, instruction and data registers
  always_comb begin
    next_state     = state;
    next_ir        = ir;
    next_ir_shift  = ir_shift;
    next_id_shift  = id_shift;
    next_bypass    = bypass;
    next_reset_dr  = reset_dr;
    next_bsc_shift = bsc_shift;
    next_bsc_upd   = bsc_upd;
    next_tdo       = tdo;
    next_tdo_oe    = tdo_oe;
    if (!tap_en) begin
      next_state  = TAP_RESET;
      next_ir     = OP_IDCODE;
      next_tdo_oe = 1'b0;
    end else begin
      if (tck_rise) begin
        next_state = tap_next(state, jtag_s2.tms);
        case (state)
          TAP_RESET: begin
            next_ir = OP_IDCODE;
          end
          TAP_CAP_IR: begin
            next_ir_shift = IR_CAPTURE_VAL;
          end
          TAP_SH_IR: begin
            next_ir_shift = {jtag_s2.tdi, ir_shift[IR_W-1:1]};
          end
          TAP_UPD_IR: begin
            next_ir = ir_shift;
          end
          TAP_CAP_DR: begin
            case (sel)
              SEL_BSC:    next_bsc_shift = bsc_capture;
              SEL_ID:     next_id_shift  = ID_VALUE;
              SEL_BYPASS: next_bypass    = 1'b0;
              default:    next_reset_dr  = reset_dr;
            endcase
          end
          TAP_SH_DR: begin
            case (sel)
              SEL_BSC:    next_bsc_shift = {jtag_s2.tdi, bsc_shift[BSC_W-1:1]};
              SEL_ID:     next_id_shift  = {jtag_s2.tdi, id_shift[ID_W-1:1]};
              SEL_BYPASS: next_bypass    = jtag_s2.tdi;
              default:    next_reset_dr  = jtag_s2.tdi;
            endcase
          end
          TAP_UPD_DR: begin
            if (sel == SEL_BSC) begin
              next_bsc_upd = bsc_shift;
            end
          end
          default: begin
            next_ir = ir;
          end
        endcase
      end
      // TDO changes on the falling edge, driven only while shifting
      if (tck_fall) begin
        next_tdo_oe = (state == TAP_SH_IR) | (state == TAP_SH_DR);
        if (state == TAP_SH_IR) begin
          next_tdo = ir_shift[0];
        end else begin
          case (sel)
            SEL_BSC:    next_tdo = bsc_shift[0];
            SEL_ID:     next_tdo = id_shift[0];
            SEL_BYPASS: next_tdo = bypass;
            default:    next_tdo = reset_dr;
          endcase
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state     <= TAP_RESET;
      ir        <= OP_IDCODE;
      ir_shift  <= '0;
      id_shift  <= '0;
      bypass    <= 1'b0;
      reset_dr  <= 1'b0;
      bsc_shift <= '0;
      bsc_upd   <= '0;
      tdo       <= 1'b0;
      tdo_oe    <= 1'b0;
    end else begin
      state     <= next_state;
      ir        <= next_ir;
      ir_shift  <= next_ir_shift;
      id_shift  <= next_id_shift;
      bypass    <= next_bypass;
      reset_dr  <= next_reset_dr;
      bsc_shift <= next_bsc_shift;
      bsc_upd   <= next_bsc_upd;
      tdo       <= next_tdo;
      tdo_oe    <= next_tdo_oe;
    end
  end

  // Reset time-out reloads while the reset bit is one
  always_comb begin
    case (clock_option_fuse)
      2'h0:    rst_load = 32'h0;
      2'h1:    rst_load = 32'(TO_SHORT_CYC);
      2'h2:    rst_load = 32'(TO_MID_CYC);
      default: rst_load = 32'(TO_LONG_CYC);
    endcase
    if (reset_dr) begin
      next_rst_cnt = rst_load;
    end else if (rst_cnt != 32'h0) begin
      next_rst_cnt = rst_cnt - 32'h1;
    end else begin
      next_rst_cnt = rst_cnt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_cnt <= 32'h0;
    end else begin
      rst_cnt <= next_rst_cnt;
    end
  end

  // Unlatched: reset follows the bit itself, then the time-out
  assign core_reset = reset_dr | (rst_cnt != 32'h0);

  // Pad drive: chain latches set data and enable under EXTEST, pull-ups off under EXTEST and SAMPLE, otherwise core values
  always_comb begin
    next_pad = core_pins;
    for (int i = 0; i < NUM_PINS; i++) begin
      if (extest_on) begin
        next_pad.data[i] = bsc_upd[i*CELLS_PER_PIN + CELL_DATA];
        next_pad.oe[i]   = bsc_upd[i*CELLS_PER_PIN + CELL_CTRL];
        next_pad.pud[i]  = 1'b1;
      end else if (scan_mode) begin
        next_pad.pud[i]  = 1'b1;
      end else begin
        next_pad.pud[i]  = core_pins.pud[i];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_q <= '0;
    end else begin
      pad_q <= next_pad;
    end
  end

  // Reset floats the pads at once unless EXTEST owns them
  always_comb begin
    pad_pins      = pad_q;
    pad_pins.oe   = (core_reset & ~extest_on) ? '0 : pad_q.oe;
  end

  // APB slave, zero wait states
  assign pready   = 1'b1;
  assign addr_hit = (paddr == ADDR_CTRL) | (paddr == ADDR_STATUS) | (paddr == ADDR_IDCODE);
  assign pslverr  = psel & penable & ~addr_hit;
  assign wr_en    = psel & penable & pwrite;

  // Register writes, read data staged in the setup cycle
  always_comb begin
    next_tap_disable_bit = tap_disable_bit;
    next_tap_reset_flag  = tap_reset_flag;
    next_prdata          = prdata;
    if (wr_en && paddr == ADDR_CTRL) begin
      next_tap_disable_bit = pwdata[CTRL_DIS_BIT];
    end
    if (wr_en && paddr == ADDR_STATUS && pwdata[ST_TAPRST_BIT]) begin
      next_tap_reset_flag = 1'b0;
    end
    if (reset_dr) begin
      next_tap_reset_flag = 1'b1;  // Set wins over clear
    end
    if (psel && !penable) begin
      next_prdata = 32'h0;
      case (paddr)
        ADDR_CTRL: begin
          next_prdata[CTRL_DIS_BIT] = tap_disable_bit;
        end
        ADDR_STATUS: begin
          next_prdata[ST_IR_LSB +: IR_W] = ir;
          next_prdata[ST_ENABLED_BIT]    = tap_en;
          next_prdata[ST_RESET_BIT]      = core_reset;
          next_prdata[ST_TAPRST_BIT]     = tap_reset_flag;
          next_prdata[ST_STATE_LSB +: 16] = state;
        end
        ADDR_IDCODE: begin
          next_prdata = ID_VALUE;
        end
        default: begin
          next_prdata = 32'h0;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tap_disable_bit <= CTRL_DIS_RST;
      tap_reset_flag  <= 1'b0;
      prdata          <= 32'h0;
    end else begin
      tap_disable_bit <= next_tap_disable_bit;
      tap_reset_flag  <= next_tap_reset_flag;
      prdata          <= next_prdata;
    end
  end

endmodule

// ### testbench/jbst_jtag_ctl.sv
/*
  Behavioural test controller driving clock, mode and data pins.
  Assumes pclk at 100 MHz; each test clock half is four pclk.
*/
`timescale 1ns/1ps
module jbst_jtag_ctl
  import jbst_pkg::*;
(
  input  wire logic     pclk,
  input  wire logic     tdo,
  input  wire logic     tdo_oe,
  output jbst_jtag_in_t jtag_in
);
  logic tdo_seen;
  logic oe_seen;

  // Pins quiet, clock parked low
  initial begin
    jtag_in  = '0;
    tdo_seen = 1'b0;
    oe_seen  = 1'b0;
  end

  // One test clock; mode and data held through the high phase
  task automatic clk(input logic m, input logic d, output logic b);
    @(posedge pclk);
    jtag_in.tck <= 1'b0;
    jtag_in.tms <= m;
    jtag_in.tdi <= d;
    repeat (4) @(posedge pclk);
    jtag_in.tck <= 1'b1;
    @(negedge pclk);
    b        = tdo_oe ? tdo : ~tdo_seen;  // Released line reads inverted
    tdo_seen = b;
    oe_seen  = oe_seen | tdo_oe;
    repeat (3) @(posedge pclk);
  endtask

  // Idle to Idle through one IR or DR scan
  task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
    logic b;
    dout    = '0;
    oe_seen = 1'b0;
    clk(1'b1, 1'b0, b);
    if (ir)
      clk(1'b1, 1'b0, b);
    clk(1'b0, 1'b0, b);
    clk(1'b0, 1'b0, b);
    for (int k = 0; k < n; k++) begin
      clk(k == n - 1, din[k], b);
      dout[k] = b;
    end
    clk(1'b1, ~din[n-1], b);
    clk(1'b0, ~din[n-1], b);
    @(posedge pclk);
    jtag_in.tck <= 1'b0;
    @(posedge pclk);  // Let outputs launched by the update settle
  endtask

  // Mode high five times, then Idle
  task automatic tap_reset();
    logic b;
    repeat (5) clk(1'b1, 1'b0, b);
    clk(1'b0, 1'b0, b);
    @(posedge pclk);
    jtag_in.tck <= 1'b0;
  endtask
endmodule

// ### testbench/jbst_tap_props.sv
/*
  Checker for the boundary-scan port, on top-level pins only.
  Assumes one pclk domain and a slow test clock.
*/
`timescale 1ns/1ps
module jbst_tap_props
  import jbst_pkg::*;
#(
  parameter int TO_MID_CYC  = 50,
  parameter int TO_LONG_CYC = 100
) (
  input wire logic          pclk,
  input wire logic          presetn,
  input wire jbst_jtag_in_t jtag_in,
  input wire logic          tdo,
  input wire logic          tdo_oe,
  input wire logic          tap_enable_fuse,
  input wire logic [1:0]    clock_option_fuse,
  input wire jbst_pins_t    core_pins,
  input wire jbst_pins_t    pad_pins,
  input wire logic          core_reset
);
  logic       tck_q;
  logic [3:0] fall_cnt;
  logic [3:0] rise_cnt;
  logic [1:0] live_cnt;
  logic       live;
  int         hi_cnt;
  int         need;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Time-out owed by each clock option
  always_comb begin
    case (clock_option_fuse)
      2'h1: need = TO_SHORT_CYC;
      2'h2: need = TO_MID_CYC;
      2'h3: need = TO_LONG_CYC;
      default: need = 0;
    endcase
  end
  assign live = (live_cnt == 2'h2);

  // Counts since test clock edges, reset length, settle after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tck_q    <= 1'b0;
      fall_cnt <= 4'hf;
      rise_cnt <= 4'hf;
      live_cnt <= 2'h0;
      hi_cnt   <= 0;
    end else begin
      tck_q    <= jtag_in.tck;
      fall_cnt <= (tck_q && !jtag_in.tck) ? 4'h0 : fall_cnt + {3'h0, fall_cnt != 4'hf};
      rise_cnt <= (!tck_q && jtag_in.tck) ? 4'h0 : rise_cnt + {3'h0, rise_cnt != 4'hf};
      live_cnt <= live ? live_cnt : live_cnt + 2'h1;
      hi_cnt   <= core_reset ? hi_cnt + 1 : 0;
    end
  end

  a_tdo_after_fall: assert property (
    tdo_oe && $past(tdo_oe) && $changed(tdo) |-> fall_cnt <= 4'h4) else $error("tdo moved off a clock fall");
  a_oe_after_fall: assert property (
    $rose(tdo_oe) |-> fall_cnt <= 4'h4) else $error("tdo enable rose off a clock fall");
  a_fuse_off_quiet: assert property (
    !tap_enable_fuse [*8] |-> !tdo_oe) else $error("tdo driven with fuse blank");
  a_reset_prompt: assert property (
    $rose(core_reset) |-> rise_cnt <= 4'h4) else $error("chip reset late after shift edge");
  a_reset_hiz: assert property (
    $rose(core_reset) |-> pad_pins.oe == '0) else $error("pads driven on chip reset");
  a_reset_timeout: assert property (
    $fell(core_reset) |-> hi_cnt >= need) else $error("chip reset released early");
  a_pads_follow: assert property (
    live && !core_reset && !(&pad_pins.pud) |->
      pad_pins.data == $past(core_pins.data) && pad_pins.oe == $past(core_pins.oe))
    else $error("pads differ from core drive");
  a_pud_choice: assert property (
    live |-> (&pad_pins.pud) || pad_pins.pud == $past(core_pins.pud)) else $error("pull-up disable wrong");

  c_chip_reset: cover property ($rose(core_reset));
  c_shift: cover property ($rose(tdo_oe));
  c_short_to: cover property ($fell(core_reset) && clock_option_fuse == 2'h1);
endmodule

// ### testbench/tb_jbst_tap.sv
/*
  Self-checking bench for the boundary-scan port.
  Assumes the controller model drives the test pins.
*/
`timescale 1ns/1ps
module tb_jbst_tap
  import jbst_pkg::*;
;
  localparam logic [3:0]  VER    = 4'h3;     // Arbitrary
  localparam logic [15:0] PART   = 16'hc3a5; // Arbitrary
  localparam logic [10:0] MFR    = 11'h2b6;  // Arbitrary
  localparam int          TMID   = 50;
  localparam int          TLONG  = 100;
  localparam logic [31:0] EXP_ID = {VER, PART, MFR, 1'b1};
  logic          pclk;
  logic          presetn;
  logic          psel;
  logic          penable;
  logic          pwrite;
  logic [11:0]   paddr;
  logic [31:0]   pwdata;
  logic [31:0]   prdata;
  logic          pready;
  logic          pslverr;
  jbst_jtag_in_t jtag_in;
  logic          tdo;
  logic          tdo_oe;
  logic          tap_enable_fuse;
  logic [1:0]    clock_option_fuse;
  jbst_pins_t    core_pins;
  logic [7:0]    pin_in;
  logic [1:0]    analog_if;
  jbst_pins_t    pad_pins;
  logic          core_reset;
  int            num_errors;
  int            comparisons;

  jbst_tap #(.ID_VERSION(VER), .ID_PART(PART), .ID_MFR(MFR), .TO_MID_CYC(TMID), .TO_LONG_CYC(TLONG)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .jtag_in(jtag_in), .tdo(tdo), .tdo_oe(tdo_oe), .tap_enable_fuse(tap_enable_fuse),
    .clock_option_fuse(clock_option_fuse), .core_pins(core_pins), .pin_in(pin_in),
    .analog_if(analog_if), .pad_pins(pad_pins), .core_reset(core_reset));
  jbst_jtag_ctl u_ctl (.pclk(pclk), .tdo(tdo), .tdo_oe(tdo_oe), .jtag_in(jtag_in));

  // Free-running bus clock
  always #(CLK_PERIOD_NS / 2) pclk = ~pclk;

  task automatic test_done();
    $display("errors=%0d comparisons=%0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Count a compare and report a difference
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer, pready waited for under a bound
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n == 20) begin
      num_errors++;
      test_done();
    end
  endtask

  // Per-pin cells and analog pair in chain order
  function automatic logic [BSC_W-1:0] chain(input logic [7:0] dv, input logic [7:0] ov, input logic [7:0] pv,
                                             input logic [1:0] av);
    logic [BSC_W-1:0] v;
    v = '0;
    for (int i = 0; i < NUM_PINS; i++) begin
      v[CELLS_PER_PIN*i+CELL_DATA] = dv[i];
      v[CELLS_PER_PIN*i+CELL_CTRL] = ov[i];
      v[CELLS_PER_PIN*i+CELL_PUD]  = pv[i];
    end
    v[BSC_W-1 -: NUM_ANALOG] = av;
    return v;
  endfunction

  task automatic t_idcode();
    logic [31:0] d;
    logic        e;
    u_ctl.scan(1'b0, 32, 32'h0, d);
    chk(d, EXP_ID);
    apb(1'b0, ADDR_IDCODE, 32'h0, d, e);
    chk(d, EXP_ID);
  endtask

  task automatic t_opcodes();
    logic [31:0] d;
    logic        e;
    for (int op = 0; op < 16; op++) begin
      u_ctl.scan(1'b1, IR_W, 32'(op), d);
      chk({28'h0, d[3:0]}, {28'h0, IR_CAPTURE_VAL});
      apb(1'b0, ADDR_STATUS, 32'h0, d, e);
      chk({28'h0, d[ST_IR_LSB +: IR_W]}, 32'(op));
      if (!(op inside {0, 1, 2, 12})) begin
        u_ctl.scan(1'b0, 8, 32'h000000b7, d);
        chk({24'h0, d[7:0]}, 32'h0000006e);
      end
    end
  endtask

  task automatic t_sample();
    logic [31:0] d;
    u_ctl.scan(1'b1, IR_W, {28'h0, OP_SAMPLE}, d);
    u_ctl.scan(1'b0, BSC_W, 32'(chain(8'h96, 8'h5c, 8'hff, 2'h0)), d);
    chk(d & 32'(chain(8'hff, 8'h00, 8'hff, 2'h3)), 32'(chain(pin_in, 8'h00, core_pins.pud, analog_if)));
    chk({8'h0, pad_pins}, {8'h0, core_pins.data, core_pins.oe, 8'hff});
  endtask

  task automatic t_extest();
    logic [31:0] d;
    u_ctl.scan(1'b1, IR_W, {28'h0, OP_EXTEST}, d);
    chk({8'h0, pad_pins}, 32'h00965cff);
    pin_in    <= 8'h3c;
    analog_if <= 2'h2;
    u_ctl.scan(1'b0, BSC_W, 32'(chain(8'h69, 8'ha3, 8'hff, 2'h0)), d);
    chk(d & 32'(chain(8'hff, 8'h00, 8'hff, 2'h3)), 32'(chain(8'h3c, 8'h00, core_pins.pud, 2'h2)));
    chk({8'h0, pad_pins}, 32'h0069a3ff);
  endtask

  task automatic t_chip_reset();
    logic [31:0] d;
    logic        e;
    int          need[4] = '{0, TO_SHORT_CYC, TMID, TLONG};
    int          n;
    u_ctl.scan(1'b1, IR_W, {28'h0, OP_CHIP_RESET}, d);
    for (int f = 0; f < 4; f++) begin
      clock_option_fuse <= 2'(f);
      u_ctl.scan(1'b0, 1, 32'h1, d);
      chk({31'h0, core_reset}, 32'h1);
      chk({24'h0, pad_pins.oe}, 32'h0);
      apb(1'b0, ADDR_STATUS, 32'h0, d, e);
      chk({26'h0, d[ST_TAPRST_BIT], d[ST_RESET_BIT], d[ST_IR_LSB +: IR_W]}, {26'h0, 2'h3, OP_CHIP_RESET});
      u_ctl.scan(1'b0, 1, 32'h0, d);
      n = 0;
      while (core_reset !== 1'b0 && n < 1000) begin
        n++;
        @(posedge pclk);
      end
      chk(32'(n + 40 >= need[f] && n <= need[f]), 32'h1);
      if (n == 1000)
        test_done();
    end
  endtask

  task automatic t_disable();
    logic [31:0] d;
    logic        e;
    apb(1'b0, ADDR_CTRL, 32'h0, d, e);
    chk(d, 32'h0);
    for (int k = 0; k < 2; k++) begin
      if (k == 0)
        apb(1'b1, ADDR_CTRL, 32'h1, d, e);
      else
        tap_enable_fuse <= 1'b0;
      u_ctl.scan(1'b1, IR_W, {28'h0, OP_BYPASS}, d);
      chk({31'h0, u_ctl.oe_seen}, 32'h0);
      apb(1'b0, ADDR_STATUS, 32'h0, d, e);
      chk({27'h0, d[ST_ENABLED_BIT], d[ST_IR_LSB +: IR_W]}, {27'h0, 1'b0, OP_IDCODE});
      apb(1'b1, ADDR_CTRL, 32'h0, d, e);
      if (k == 1)
        tap_enable_fuse <= 1'b1;
    end
    apb(1'b0, 12'h00c, 32'h0, d, e);
    chk({31'h0, e}, 32'h1);
    u_ctl.tap_reset();
  endtask

  task automatic t_tlr();
    logic [31:0] d;
    logic        e;
    logic        b;
    u_ctl.scan(1'b1, IR_W, {28'h0, OP_BYPASS}, d);
    u_ctl.clk(1'b1, 1'b0, b);
    u_ctl.clk(1'b0, 1'b0, b);
    u_ctl.clk(1'b0, 1'b0, b);
    u_ctl.tap_reset();
    apb(1'b0, ADDR_STATUS, 32'h0, d, e);
    chk({12'h0, d[ST_STATE_LSB +: 16], d[ST_IR_LSB +: IR_W]}, {12'h0, TAP_IDLE, OP_IDCODE});
  endtask

  // Reset, then scenarios in turn
  initial begin
    pclk              = 1'b0;
    presetn           = 1'b0;
    psel              = 1'b0;
    penable           = 1'b0;
    pwrite            = 1'b0;
    paddr             = 12'h000;
    pwdata            = 32'h0;
    tap_enable_fuse   = 1'b1;
    clock_option_fuse = 2'h1;
    core_pins         = {8'ha5, 8'hf0, 8'h0f};
    pin_in            = 8'hc3;
    analog_if         = 2'h1;
    num_errors        = 0;
    comparisons       = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    u_ctl.tap_reset();
    t_idcode();
    t_opcodes();
    t_sample();
    t_extest();
    t_chip_reset();
    t_disable();
    t_tlr();
    test_done();
  end
endmodule

bind jbst_tap jbst_tap_props #(.TO_MID_CYC(TO_MID_CYC), .TO_LONG_CYC(TO_LONG_CYC)) u_props (
  .pclk(pclk), .presetn(presetn), .jtag_in(jtag_in), .tdo(tdo), .tdo_oe(tdo_oe),
  .tap_enable_fuse(tap_enable_fuse), .clock_option_fuse(clock_option_fuse),
  .core_pins(core_pins), .pad_pins(pad_pins), .core_reset(core_reset));
